//--- verilog/tdm_switch_consts.vh
// Constants for the time-slot switch memory map
`ifndef TDM_SWITCH_CONSTS_VH
`define TDM_SWITCH_CONSTS_VH
`define ADDR_SEL_BIT 14
`define ADDR_STREAM_HI 13
`define ADDR_STREAM_LO 9
`define ADDR_CHAN_HI 8
`define ADDR_CHAN_LO 0
`define CW_SRC_BIT 15
`define CW_MSG_BIT 14
`define CW_EN_BIT 13
`define CW_STREAM_HI 12
`define CW_STREAM_LO 8
`define CW_CHAN_HI 7
`define CW_CHAN_LO 0
`define RATE_2M 2'h0
`define RATE_4M 2'h1
`define RATE_8M 2'h2
`define RATE_16M 2'h3
`define CHAN_MAX_2M 8'h1F
`define CHAN_MAX_4M 8'h3F
`define CHAN_MAX_8M 8'h7F
`define CHAN_MAX_16M 8'hFF
`define MSEL_BDM 2'h0
`define MSEL_LDM 2'h1
`define MSEL_LCM 2'h2
`define MSEL_BCM 2'h3
`endif

//--- verilog/sample_fifo.v
// No logic of its own: the receive FIFO module sits in the switch file

//--- verilog/tdm_switch_memory_map.v
// Data and connection stores of the time-slot switch with host port
`timescale 1ns/1ps
`include "tdm_switch_consts.vh"
// What this block does
// - A14 high memories, low registers
// - Address holds stream and channel fields
// - Channel range limited by stream rate
// - Received bytes stored per stream, channel
// - Backplane store 4096 bytes, upper zero
// - Local store 4096 bytes, upper zero
// - Local connection store 4096 words
// - Local bit15 picks backplane or local
// - Local bit14 sends message byte
// - Local bit13 enables channel drive
// - Local stream and channel source fields
// - Backplane connection store 4096 words
// - Backplane bit15 picks local or backplane
// - Backplane bit14 sends message byte
// - Backplane bit13 enables channel drive
// - Backplane stream field, ignored in message
// - Backplane low byte channel or message
// - Test pattern overrides source, keeps enable
module tdm_switch_memory_map #(
    parameter ENTRIES = 4096,
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW = 5
) (
    input wire clock_i,
    input wire rst_b_i,
    input wire ce_i,
    // Host microport
    input wire host_req_i,
    input wire host_wr_i,
    input wire [14:0] host_addr_i,
    input wire [1:0] host_mem_sel_i,
    input wire [15:0] host_wdata_i,
    output reg [15:0] host_rdata_o,
    output reg host_ack_o,
    output wire host_reg_req_o,
    // Received channel bytes from deserialisers
    input wire rx_valid_i,
    output wire rx_ready_o,
    input wire rx_port_i,
    input wire [3:0] rx_stream_i,
    input wire [7:0] rx_chan_i,
    input wire [7:0] rx_byte_i,
    input wire [31:0] rx_rate_i,
    // Output channel slot request
    input wire slot_req_i,
    input wire slot_port_i,
    input wire [3:0] slot_stream_i,
    input wire [7:0] slot_chan_i,
    input wire [31:0] tx_rate_i,
    input wire ber_tx_active_i,
    input wire [7:0] ber_tx_byte_i,
    input wire local_output_drive_select_i,
    input wire backplane_output_drive_select_i,
    output reg out_valid_o,
    output reg out_port_o,
    output reg [3:0] out_stream_o,
    output reg [7:0] out_chan_o,
    output reg [7:0] out_byte_o,
    output reg out_pin_oe_o,
    output reg out_ext_buf_en_o
);
    reg [7:0] backplane_rx_store [0:ENTRIES-1];
    reg [7:0] local_rx_store [0:ENTRIES-1];
    reg [15:0] local_out_conn_store [0:ENTRIES-1];
    reg [15:0] backplane_out_conn_store [0:ENTRIES-1];

    function [7:0] chan_max;
        input [1:0] rate;
        begin
            case (rate)
                `RATE_2M: chan_max = `CHAN_MAX_2M;
                `RATE_4M: chan_max = `CHAN_MAX_4M;
                `RATE_8M: chan_max = `CHAN_MAX_8M;
                default: chan_max = `CHAN_MAX_16M;
            endcase
        end
    endfunction

    // Highest used channel of every stream, from the two rate words
    wire [7:0] rx_lim [0:15];
    wire [7:0] tx_lim [0:15];
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : stream_limit
            assign rx_lim[g] = chan_max(rx_rate_i[2*g+1:2*g]);
            assign tx_lim[g] = chan_max(tx_rate_i[2*g+1:2*g]);
        end
    endgenerate

    // Host address decode
    wire mem_sel = host_addr_i[`ADDR_SEL_BIT];
    wire [3:0] h_stream = host_addr_i[`ADDR_STREAM_LO+3:`ADDR_STREAM_LO];
    wire h_stream_ok = (host_addr_i[`ADDR_STREAM_HI] == 1'b0);
    wire [7:0] h_chan = host_addr_i[`ADDR_CHAN_LO+7:`ADDR_CHAN_LO];
    wire h_chan_ok = (host_addr_i[`ADDR_CHAN_HI] == 1'b0);
    wire [11:0] h_idx = {h_stream, h_chan};
    wire h_ok = h_stream_ok && h_chan_ok;
    assign host_reg_req_o = host_req_i && !mem_sel;

    // Incoming bytes are buffered so a busy host cycle cannot drop them
    wire [20:0] fifo_out;
    wire fifo_valid;
    wire host_mem_cyc = host_req_i && mem_sel;
    // Host wins the memory port; drain stalls for every host memory cycle
    wire fifo_pop = fifo_valid && !host_mem_cyc;
    sample_fifo #(
        .WIDTH(21),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_rx_fifo (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .in_valid_i(rx_valid_i),
        .in_ready_o(rx_ready_o),
        .in_data_i({rx_port_i, rx_stream_i, rx_chan_i, rx_byte_i}),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out)
    );
    wire f_port = fifo_out[20];
    wire [3:0] f_stream = fifo_out[19:16];
    wire [7:0] f_chan = fifo_out[15:8];
    wire [7:0] f_byte = fifo_out[7:0];
    wire f_in_range = (f_chan <= rx_lim[f_stream]);

    // Output slot lookup, stage 1: fetch connection word
    reg s1_valid_q;
    reg s1_port_q;
    reg [3:0] s1_stream_q;
    reg [7:0] s1_chan_q;
    reg [15:0] s1_word_q;
    reg s1_ber_q;
    reg [7:0] s1_ber_byte_q;
    reg s1_range_q;
    wire [11:0] t_idx = {slot_stream_i, slot_chan_i};

    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            host_rdata_o <= 16'h0000;
            host_ack_o <= 1'b0;
        end else if (ce_i) begin
            host_ack_o <= host_mem_cyc;
            if (host_mem_cyc) begin
                host_rdata_o <= 16'h0000;
                if (!host_wr_i && h_ok) begin
                    case (host_mem_sel_i)
                        `MSEL_BDM: host_rdata_o <= {8'h00, backplane_rx_store[h_idx]};
                        `MSEL_LDM: host_rdata_o <= {8'h00, local_rx_store[h_idx]};
                        `MSEL_LCM: host_rdata_o <= local_out_conn_store[h_idx];
                        default: host_rdata_o <= backplane_out_conn_store[h_idx];
                    endcase
                end
            end
        end
    end

    // Host writes to connection stores; data stores are read-only to the host
    always @(posedge clock_i) begin
        if (ce_i && rst_b_i && host_mem_cyc && host_wr_i && h_ok) begin
            if (host_mem_sel_i == `MSEL_LCM) begin
                local_out_conn_store[h_idx] <= host_wdata_i;
            end
            if (host_mem_sel_i == `MSEL_BCM) begin
                backplane_out_conn_store[h_idx] <= host_wdata_i;
            end
        end
    end

    // Received bytes written in sequence, out-of-range channels dropped
    always @(posedge clock_i) begin
        if (ce_i && rst_b_i && fifo_pop && f_in_range) begin
            if (f_port) begin
                local_rx_store[{f_stream, f_chan}] <= f_byte;
            end else begin
                backplane_rx_store[{f_stream, f_chan}] <= f_byte;
            end
        end
    end

    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            s1_valid_q <= 1'b0;
            s1_port_q <= 1'b0;
            s1_stream_q <= 4'h0;
            s1_chan_q <= 8'h00;
            s1_word_q <= 16'h0000;
            s1_ber_q <= 1'b0;
            s1_ber_byte_q <= 8'h00;
            s1_range_q <= 1'b0;
        end else if (ce_i) begin
            s1_valid_q <= slot_req_i;
            s1_port_q <= slot_port_i;
            s1_stream_q <= slot_stream_i;
            s1_chan_q <= slot_chan_i;
            s1_ber_q <= ber_tx_active_i;
            s1_ber_byte_q <= ber_tx_byte_i;
            s1_range_q <= (slot_chan_i <= tx_lim[slot_stream_i]);
            if (slot_port_i) begin
                s1_word_q <= backplane_out_conn_store[t_idx];
            end else begin
                s1_word_q <= local_out_conn_store[t_idx];
            end
        end
    end

    // Stage 2: decode the word and fetch the byte
    wire w_src = s1_word_q[`CW_SRC_BIT];
    wire w_msg = s1_word_q[`CW_MSG_BIT];
    wire w_en = s1_word_q[`CW_EN_BIT];
    wire [3:0] w_stream = s1_word_q[`CW_STREAM_LO+3:`CW_STREAM_LO];
    wire [7:0] w_chan = s1_word_q[`CW_CHAN_HI:`CW_CHAN_LO];
    wire [11:0] w_idx = {w_stream, w_chan};
    // Local output: bit15 high means local store; backplane output is the reverse
    wire use_local = s1_port_q ? !w_src : w_src;
    wire drive_sel = s1_port_q ? backplane_output_drive_select_i : local_output_drive_select_i;
    reg [7:0] sw_byte;
    always @* begin
        sw_byte = use_local ? local_rx_store[w_idx] : backplane_rx_store[w_idx];
    end

    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            out_valid_o <= 1'b0;
            out_port_o <= 1'b0;
            out_stream_o <= 4'h0;
            out_chan_o <= 8'h00;
            out_byte_o <= 8'h00;
            out_pin_oe_o <= 1'b0;
            out_ext_buf_en_o <= 1'b0;
        end else if (ce_i) begin
            out_valid_o <= s1_valid_q;
            out_port_o <= s1_port_q;
            out_stream_o <= s1_stream_q;
            out_chan_o <= s1_chan_q;
            if (s1_ber_q) begin
                out_byte_o <= s1_ber_byte_q;
            end else if (w_msg) begin
                out_byte_o <= w_chan;
            end else begin
                out_byte_o <= sw_byte;
            end
            // Enable still applies under test pattern; unused channels stay off
            // Drive select high: pin driven on every valid in-range slot, external buffer gated instead
            out_pin_oe_o <= s1_valid_q && s1_range_q &&
                (w_en || drive_sel);
            out_ext_buf_en_o <= s1_valid_q && s1_range_q && w_en;
        end
    end
endmodule

// Parameterised valid/ready FIFO
module sample_fifo #(
    parameter WIDTH = 21,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clock_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_q;
    reg [AW:0] rd_q;
    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = (wr_q == rd_q);
    // Frozen clock takes nothing, so ready must not promise a slot
    assign in_ready_o = ce_i && !full;
    assign out_valid_o = ce_i && !empty;
    assign out_data_o = mem[rd_q[AW-1:0]];
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else if (ce_i) begin
            if (in_valid_i && !full) begin
                mem[wr_q[AW-1:0]] <= in_data_i;
                wr_q <= wr_q + 1'b1;
            end
            if (out_ready_i && !empty) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

//--- tb/tdm_switch_checker.sv
// Port checker for the time-slot switch stores
`timescale 1ns/1ps
module tdm_switch_checker (
    input wire clock_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire host_req_i,
    input wire host_wr_i,
    input wire [14:0] host_addr_i,
    input wire [1:0] host_mem_sel_i,
    input wire [15:0] host_rdata_o,
    input wire host_ack_o,
    input wire host_reg_req_o,
    input wire slot_req_i,
    input wire slot_port_i,
    input wire [7:0] slot_chan_i,
    input wire ber_tx_active_i,
    input wire [7:0] ber_tx_byte_i,
    input wire out_valid_o,
    input wire out_port_o,
    input wire [7:0] out_chan_o,
    input wire [7:0] out_byte_o,
    input wire out_pin_oe_o,
    input wire out_ext_buf_en_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    wire mem_acc = ce_i && host_req_i && host_addr_i[14];
    AST_MEM_ACK: assert property (mem_acc |=> host_ack_o)
        else $error("no ack after memory access");
    AST_REG_NOACK: assert property (ce_i && !mem_acc |=> !host_ack_o)
        else $error("ack without memory access");
    AST_REG_REQ: assert property (host_reg_req_o == (host_req_i && !host_addr_i[14]))
        else $error("register request decode wrong");
    AST_RX_HIGH_ZERO: assert property (mem_acc && !host_wr_i && !host_mem_sel_i[1] |=>
        host_rdata_o[15:8] == 8'h00) else $error("data store upper byte not zero");
    AST_SLOT_LAT: assert property (ce_i && slot_req_i |-> ##2 out_valid_o)
        else $error("slot result missing");
    AST_SLOT_IDLE: assert property (ce_i && !slot_req_i |-> ##2 !out_valid_o)
        else $error("slot result without request");
    AST_SLOT_ECHO: assert property (slot_req_i |-> ##2 out_port_o == $past(slot_port_i, 2)
        && out_chan_o == $past(slot_chan_i, 2)) else $error("slot tag mismatch");
    AST_BER_BYTE: assert property (slot_req_i && ber_tx_active_i |-> ##2
        out_byte_o == $past(ber_tx_byte_i, 2)) else $error("test byte not sent");
    AST_EXT_OE: assert property (out_ext_buf_en_o |-> out_pin_oe_o)
        else $error("buffer enable without drive");
endmodule
bind tdm_switch_memory_map tdm_switch_checker tdm_switch_checker_inst (.clock_i, .rst_b_i,
    .ce_i, .host_req_i, .host_wr_i, .host_addr_i, .host_mem_sel_i, .host_rdata_o, .host_ack_o,
    .host_reg_req_o, .slot_req_i, .slot_port_i, .slot_chan_i, .ber_tx_active_i, .ber_tx_byte_i,
    .out_valid_o, .out_port_o, .out_chan_o, .out_byte_o, .out_pin_oe_o, .out_ext_buf_en_o);

//--- tb/host_model.sv
// Host processor model on the microport
`timescale 1ns/1ps
module host_model (
    input wire clock_i,
    input wire ack_i,
    input wire [15:0] rdata_i,
    output reg req_o = 1'b0,
    output reg wr_o = 1'b0,
    output reg [14:0] addr_o = 15'h0000,
    output reg [1:0] sel_o = 2'h0,
    output reg [15:0] wdata_o = 16'h0000
);
    // Called at a falling edge; one sampled edge is one access
    task access(input m, input w, input [1:0] s, input [3:0] st, input [7:0] ch,
            input [15:0] d, output [15:0] q, output ak);
        begin
            {req_o, wr_o, sel_o, wdata_o} = {1'b1, w, s, d};
            addr_o = {m, 1'b0, st, 1'b0, ch};
            @(negedge clock_i);
            // Ack stands one cycle only, so it is taken before release
            q = rdata_i;
            ak = ack_i;
            req_o = 1'b0;
            // Released lines show junk, not the last value
            addr_o = ~addr_o;
            wdata_o = ~wdata_o;
            @(negedge clock_i);
        end
    endtask
    // Back-to-back reads keep the store port busy
    task hold(input integer n);
        begin
            {req_o, wr_o, sel_o, addr_o} = {1'b1, 1'b0, 2'h0, 15'h4000};
            repeat (n) @(negedge clock_i);
            req_o = 1'b0;
        end
    endtask
endmodule

//--- tb/test_tdm_switch_memory_map.sv
// Self-checking bench for the time-slot switch stores
`timescale 1ns/1ps
module test_tdm_switch_memory_map;
    reg clock_i = 0, rst_b_i = 0, rx_valid_i = 0, rx_port_i = 0, lsel = 0, bsel = 0, a;
    reg slot_req_i = 0, slot_port_i = 0, ber_tx_active_i = 0;
    reg [3:0] rx_stream_i = 0, slot_stream_i = 0;
    reg [7:0] rx_chan_i = 0, rx_byte_i = 0, slot_chan_i = 0, ber_tx_byte_i = 0, b;
    reg [31:0] rx_rate_i = 32'hFFFFFFFF, tx_rate_i = 32'hFFFFFF3F, r;
    reg [15:0] q, w;
    reg [7:0] store [0:1][0:4095];
    reg [15:0] conn [0:1][0:4095];
    wire [14:0] addr;
    wire [15:0] wdata, rdata;
    wire [1:0] msel;
    wire req, wr, ack, rx_ready_o, ovalid, oport, oe, ext;
    wire [3:0] ostream;
    wire [7:0] ochan, obyte;
    integer seed = 17957, n_mismatch = 0, checked = 0, i, k, inr;
    always #50 clock_i = ~clock_i;
    tdm_switch_memory_map tdm_switch_memory_map_inst (.clock_i, .rst_b_i, .ce_i(1'b1),
        .host_req_i(req), .host_wr_i(wr), .host_addr_i(addr), .host_mem_sel_i(msel),
        .host_wdata_i(wdata), .host_rdata_o(rdata), .host_ack_o(ack), .host_reg_req_o(),
        .rx_valid_i, .rx_ready_o, .rx_port_i, .rx_stream_i, .rx_chan_i, .rx_byte_i, .rx_rate_i,
        .slot_req_i, .slot_port_i, .slot_stream_i, .slot_chan_i, .tx_rate_i, .ber_tx_active_i,
        .ber_tx_byte_i, .local_output_drive_select_i(lsel),
        .backplane_output_drive_select_i(bsel), .out_valid_o(ovalid), .out_port_o(oport),
        .out_stream_o(ostream), .out_chan_o(ochan), .out_byte_o(obyte), .out_pin_oe_o(oe),
        .out_ext_buf_en_o(ext));
    host_model host_model_inst (.clock_i, .ack_i(ack), .rdata_i(rdata), .req_o(req), .wr_o(wr),
        .addr_o(addr), .sel_o(msel), .wdata_o(wdata));
    task print_verdict;
        begin
            $display("checked %0d mismatches %0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // Valid is left high for the next caller to avoid a double drive
    task push(input p, input [3:0] s, input [7:0] c, input [7:0] d);
        begin
            {rx_valid_i, rx_port_i, rx_stream_i, rx_chan_i, rx_byte_i} = {1'b1, p, s, c, d};
            store[p][{s, c}] = d;
            k = 0;
            while (rx_ready_o !== 1'b1 && k < 60) begin
                @(negedge clock_i);
                k = k + 1;
            end
            if (k == 60) begin
                n_mismatch = n_mismatch + 1;
                print_verdict;
            end
            @(negedge clock_i);
        end
    endtask
    task slot(input p, input [3:0] s, input [7:0] c, input bt, input [7:0] bb);
        begin
            {slot_req_i, slot_port_i, slot_stream_i, slot_chan_i} = {1'b1, p, s, c};
            {ber_tx_active_i, ber_tx_byte_i} = {bt, bb};
            @(negedge clock_i);
            slot_req_i = 1'b0;
            @(negedge clock_i);
            w = conn[p][{s, c}];
            inr = c < (32 << tx_rate_i[{s, 1'b0} +: 2]);
            b = bt ? bb : w[14] ? w[7:0] : store[w[15] ^ p][w[11:0]];
            chk("valid", 16'h0001, {15'h0000, ovalid});
            chk("port", {15'h0000, p}, {15'h0000, oport});
            chk("stream", {12'h000, s}, {12'h000, ostream});
            chk("chan", {8'h00, c}, {8'h00, ochan});
            if (inr) chk("byte", {8'h00, b}, {8'h00, obyte});
            chk("oe", inr & (w[13] | (p ? bsel : lsel)), {15'h0000, oe});
            chk("extbuf", inr & w[13], {15'h0000, ext});
        end
    endtask
    initial begin
        repeat (2) @(negedge clock_i);
        rst_b_i = 1'b1;
        fork
            host_model_inst.hold(40);
            begin
                for (i = 0; i < 32; i = i + 1) begin
                    r = $random(seed);
                    push(i[0], i[4:1], i[7:0] * 8'h07, r[7:0]);
                end
                chk("rxready", 16'h0000, {15'h0000, rx_ready_o});
                rx_valid_i = 1'b0;
            end
        join
        repeat (40) @(negedge clock_i);
        for (i = 0; i < 32; i = i + 1) begin
            host_model_inst.access(1'b1, 1'b0, {1'b0, i[0]}, i[4:1], i[7:0] * 8'h07, 16'h0, q, a);
            chk("rxstore", {8'h00, store[i[0]][{i[4:1], i[7:0] * 8'h07}]}, q);
            chk("memack", 16'h0001, {15'h0000, a});
        end
        $display("fifo and data store test done");
        r = $random(seed);
        push(1'b0, 4'h5, 8'h21, r[7:0]);
        push(1'b1, 4'h5, 8'h21, r[15:8]);
        rx_valid_i = 1'b0;
        repeat (4) @(negedge clock_i);
        for (i = 0; i < 33; i = i + 1) begin
            r = $random(seed);
            w = {i[2:0], 1'b0, 4'h5, i[1] ? r[7:0] : 8'h21};
            if (i == 32) w = 16'h2521;
            conn[i[3]][{i == 32 ? 4'h3 : 4'h2, i[7:0]}] = w;
            host_model_inst.access(1'b1, 1'b1, {1'b1, i[3]}, i == 32 ? 4'h3 : 4'h2, i[7:0], w, q, a);
            host_model_inst.access(1'b1, 1'b0, {1'b1, i[3]}, i == 32 ? 4'h3 : 4'h2, i[7:0], 0, q, a);
            chk("conn", w, q);
            chk("connack", 16'h0001, {15'h0000, a});
            {lsel, bsel} = r[9:8];
            slot(i[3], i == 32 ? 4'h3 : 4'h2, i[7:0], i[4], r[23:16]);
        end
        $display("connection and slot test done");
        host_model_inst.access(1'b0, 1'b0, 2'h0, 4'h0, 8'h00, 16'h0, q, a);
        chk("regack", 16'h0000, {15'h0000, a});
        $display("register select test done");
        print_verdict;
    end
endmodule
